/* rtl/jip_cfg.svh */
// constants of the jtag instruction port: opcodes, capture pattern, timing
// assumes a 20 MHz system clock and a jtag link sampled by it
`ifndef JIP_CFG_SVH
`define JIP_CFG_SVH

`define JIP_IR_LEN        8
`define JIP_DR_LEN        32
`define JIP_BSR_LEN       16
`define JIP_OP_BYPASS     8'hff
`define JIP_OP_SAMPLE     8'h01
`define JIP_OP_EXTEST     8'h00
`define JIP_OP_CLAMP      8'hfa
`define JIP_OP_FLOAT      8'hfc
`define JIP_OP_IDENT      8'hfe
`define JIP_OP_USER       8'hfd
`define JIP_OP_RELOAD     8'hee
`define JIP_CAP_HI        3'h0
`define JIP_CAP_B2        1'h0
`define JIP_CAP_LO        2'h1
// arbitrary neutral identity value, lsb one
`define JIP_IDENT_WORD    32'h0a5a5001
`define JIP_USER_BLANK    32'hffffffff
`define JIP_CLK_NS        50
`define JIP_RELOAD_MIN_NS 300
`define JIP_RELOAD_MAX_NS 500
`define JIP_RELOAD_CYC    ((`JIP_RELOAD_MIN_NS + `JIP_RELOAD_MAX_NS) / 2 / `JIP_CLK_NS)

`endif

/* rtl/jip_link_if.sv */
// synchronised jtag link events passed from the pin sampler to the port logic
// assumes both ends run on the same system clock
`timescale 1ns/1ns
`default_nettype none
interface jip_link_if;
    logic tck_rise;
    logic tck_fall;
    logic tms;
    logic tdi;
    logic oe_reset_n;
    modport src (output tck_rise, output tck_fall, output tms, output tdi, output oe_reset_n);
    modport dst (input tck_rise, input tck_fall, input tms, input tdi, input oe_reset_n);
endinterface
`default_nettype wire

/* rtl/jip_pin_sync.sv */
// two-stage synchronisers for the link pins and tck edge detection
// assumes pins are asynchronous to clk
`timescale 1ns/1ns
`default_nettype none
module jip_pin_sync
    import jip_pkg::*;
(
    input  wire logic clk,
    input  wire logic srst,
    input  wire logic tck,
    input  wire logic tms,
    input  wire logic tdi,
    input  wire logic oe_reset_n,
    jip_link_if.src   link
);
    logic [3:0] meta_reg;
    logic [3:0] sync_reg;
    logic       tck_old_reg;
    logic [3:0] meta_next;
    logic [3:0] sync_next;
    logic       tck_old_next;

    always_comb begin
        meta_next    = {oe_reset_n, tdi, tms, tck};
        sync_next    = meta_reg;
        tck_old_next = sync_reg[0];
        // idle pin levels: tck low, the rest high, so no false edge after reset
        if (srst) begin
            meta_next    = 4'he;
            sync_next    = 4'he;
            tck_old_next = 1'b0;
        end
    end

    always_ff @(posedge clk) begin
        meta_reg    <= meta_next;
        sync_reg    <= sync_next;
        tck_old_reg <= tck_old_next;
    end

    assign link.tck_rise   = sync_reg[0] & ~tck_old_reg;
    assign link.tck_fall   = ~sync_reg[0] & tck_old_reg;
    assign link.tms        = sync_reg[1];
    assign link.tdi        = sync_reg[2];
    assign link.oe_reset_n = sync_reg[3];
endmodule // jip_pin_sync
`default_nettype wire

/* rtl/jip_pkg.sv */
// types of the jtag instruction port
// assumes nothing beyond the constants header
package jip_pkg;
    typedef enum logic [3:0] {
        TAP_RESET, TAP_IDLE, TAP_SEL_DR, TAP_CAP_DR, TAP_SH_DR, TAP_EX1_DR, TAP_PAU_DR, TAP_EX2_DR,
        TAP_UPD_DR, TAP_SEL_IR, TAP_CAP_IR, TAP_SH_IR, TAP_EX1_IR, TAP_PAU_IR, TAP_EX2_IR, TAP_UPD_IR
    } jip_tap_t;
    typedef enum logic [2:0] {
        SEL_BYPASS, SEL_BOUNDARY, SEL_IDENT, SEL_USER
    } jip_sel_t;
endpackage

/* rtl/jip_port.sv */
// jtag instruction port: tap controller, instruction and data registers,
// read lock, reload pulse and output float/clamp control
// assumes programming engine status arrives on clk; pins arrive asynchronously
`timescale 1ns/1ns
`include "jip_cfg.svh"
`default_nettype none
module jip_port
    import jip_pkg::*;
(
    input  wire logic                    clk,
    input  wire logic                    srst,
    input  wire logic                    tck,
    input  wire logic                    tms,
    input  wire logic                    tdi,
    input  wire logic                    oe_reset_n,
    input  wire logic                    isp_active,
    input  wire logic                    lock_program,
    input  wire logic                    full_erase,
    input  wire logic                    user_word_valid,
    input  wire logic [31:0]             user_word,
    input  wire logic [`JIP_BSR_LEN-1:0] pins_in,
    output logic                         tdo,
    output logic                         tdo_oe_n,
    output logic                         target_reload_n,
    output logic                         target_reload_oe_n,
    output logic                         outputs_float,
    output logic                         outputs_clamp,
    output logic [`JIP_BSR_LEN-1:0]      boundary_out,
    output logic                         boundary_drive,
    output logic                         read_permit,
    output logic                         program_permit,
    output logic                         isp_ready
);
    jip_link_if link ();

    jip_pin_sync u_sync (
        .clk        (clk),
        .srst       (srst),
        .tck        (tck),
        .tms        (tms),
        .tdi        (tdi),
        .oe_reset_n (oe_reset_n),
        .link       (link.src)
    );

    ////////////////////////////////////////////////////////////////////////
    // state
    jip_tap_t                tap_reg,     tap_next;
    logic [`JIP_IR_LEN-1:0]  ir_sh_reg,   ir_sh_next;
    logic [`JIP_IR_LEN-1:0]  instruction_reg, instruction_next;
    logic [`JIP_DR_LEN-1:0]  dr_reg,      dr_next;
    logic [`JIP_BSR_LEN-1:0] bsr_reg,     bsr_next;
    logic                    tdo_reg,     tdo_next;
    logic                    tdo_oe_n_reg, tdo_oe_n_next;
    logic                    lock_reg,    lock_next;
    logic                    rst_seen_reg, rst_seen_next;
    logic [3:0]              pulse_cnt_reg, pulse_cnt_next;
    logic                    reload_oe_n_reg, reload_oe_n_next;
    logic                    float_reg,   float_next;
    logic                    clamp_reg,   clamp_next;
    logic                    drive_reg,   drive_next;
    jip_sel_t                sel;

    ////////////////////////////////////////////////////////////////////////
    // instruction decode
    always_comb begin
        case (instruction_reg)
            `JIP_OP_SAMPLE, `JIP_OP_EXTEST: sel = SEL_BOUNDARY;
            `JIP_OP_IDENT:                  sel = SEL_IDENT;
            `JIP_OP_USER:                   sel = SEL_USER;
            default:                        sel = SEL_BYPASS;
        endcase
    end

    ////////////////////////////////////////////////////////////////////////
    // tap controller and shift paths
    always_comb begin
        tap_next         = tap_reg;
        ir_sh_next       = ir_sh_reg;
        instruction_next = instruction_reg;
        dr_next          = dr_reg;
        bsr_next         = bsr_reg;
        tdo_next         = tdo_reg;
        tdo_oe_n_next    = tdo_oe_n_reg;
        if (link.tck_rise) begin
            case (tap_reg)
                TAP_RESET:  tap_next = link.tms ? TAP_RESET  : TAP_IDLE;
                TAP_IDLE:   tap_next = link.tms ? TAP_SEL_DR : TAP_IDLE;
                TAP_SEL_DR: tap_next = link.tms ? TAP_SEL_IR : TAP_CAP_DR;
                TAP_CAP_DR: tap_next = link.tms ? TAP_EX1_DR : TAP_SH_DR;
                TAP_SH_DR:  tap_next = link.tms ? TAP_EX1_DR : TAP_SH_DR;
                TAP_EX1_DR: tap_next = link.tms ? TAP_UPD_DR : TAP_PAU_DR;
                TAP_PAU_DR: tap_next = link.tms ? TAP_EX2_DR : TAP_PAU_DR;
                TAP_EX2_DR: tap_next = link.tms ? TAP_UPD_DR : TAP_SH_DR;
                TAP_UPD_DR: tap_next = link.tms ? TAP_SEL_DR : TAP_IDLE;
                TAP_SEL_IR: tap_next = link.tms ? TAP_RESET  : TAP_CAP_IR;
                TAP_CAP_IR: tap_next = link.tms ? TAP_EX1_IR : TAP_SH_IR;
                TAP_SH_IR:  tap_next = link.tms ? TAP_EX1_IR : TAP_SH_IR;
                TAP_EX1_IR: tap_next = link.tms ? TAP_UPD_IR : TAP_PAU_IR;
                TAP_PAU_IR: tap_next = link.tms ? TAP_EX2_IR : TAP_PAU_IR;
                TAP_EX2_IR: tap_next = link.tms ? TAP_UPD_IR : TAP_SH_IR;
                TAP_UPD_IR: tap_next = link.tms ? TAP_SEL_DR : TAP_IDLE;
                default:    tap_next = TAP_RESET;
            endcase
            case (tap_reg)
                TAP_RESET: instruction_next = `JIP_OP_IDENT;
                TAP_CAP_IR: begin
                    ir_sh_next = {`JIP_CAP_HI, isp_active, lock_reg,
                                  `JIP_CAP_B2, `JIP_CAP_LO};
                end
                TAP_SH_IR: ir_sh_next = {link.tdi, ir_sh_reg[`JIP_IR_LEN-1:1]};
                TAP_UPD_IR: instruction_next = ir_sh_reg;
                TAP_CAP_DR: begin
                    case (sel)
                        SEL_IDENT: dr_next = `JIP_IDENT_WORD;
                        SEL_USER: begin
                            // locked parts read back ones, hiding stored data
                            if (lock_reg || !user_word_valid) begin
                                dr_next = `JIP_USER_BLANK;
                            end else begin
                                dr_next = user_word;
                            end
                        end
                        SEL_BOUNDARY: dr_next = {{(`JIP_DR_LEN-`JIP_BSR_LEN){1'b0}}, pins_in};
                        default: dr_next = '0;
                    endcase
                end
                TAP_SH_DR: begin
                    case (sel)
                        SEL_IDENT, SEL_USER: dr_next = {link.tdi, dr_reg[`JIP_DR_LEN-1:1]};
                        SEL_BOUNDARY: dr_next = {{(`JIP_DR_LEN-`JIP_BSR_LEN){1'b0}},
                                                 link.tdi, dr_reg[`JIP_BSR_LEN-1:1]};
                        default: dr_next = {{(`JIP_DR_LEN-1){1'b0}}, link.tdi};
                    endcase
                end
                TAP_UPD_DR: begin
                    if (sel == SEL_BOUNDARY) begin
                        bsr_next = dr_reg[`JIP_BSR_LEN-1:0];
                    end
                end
                default: ;
            endcase
        end
        if (link.tck_fall) begin
            tdo_oe_n_next = 1'b1;
            if (tap_reg == TAP_SH_IR) begin
                tdo_next      = ir_sh_reg[0];
                tdo_oe_n_next = 1'b0;
            end else if (tap_reg == TAP_SH_DR) begin
                tdo_next      = dr_reg[0];
                tdo_oe_n_next = 1'b0;
            end
        end
        if (srst) begin
            tap_next         = TAP_RESET;
            ir_sh_next       = '0;
            instruction_next = `JIP_OP_IDENT;
            dr_next          = '0;
            bsr_next         = '0;
            tdo_next         = 1'b1;
            tdo_oe_n_next    = 1'b1;
        end
    end

    always_ff @(posedge clk) begin
        tap_reg         <= tap_next;
        ir_sh_reg       <= ir_sh_next;
        instruction_reg <= instruction_next;
        dr_reg          <= dr_next;
        bsr_reg         <= bsr_next;
        tdo_reg         <= tdo_next;
        tdo_oe_n_reg    <= tdo_oe_n_next;
    end

    ////////////////////////////////////////////////////////////////////////
    // lock, reload pulse, output control
    always_comb begin
        lock_next        = lock_reg;
        rst_seen_next    = rst_seen_reg;
        pulse_cnt_next   = pulse_cnt_reg;
        reload_oe_n_next = 1'b1;
        if (full_erase) begin
            lock_next = 1'b0;
        end
        if (lock_program) begin
            lock_next = 1'b1;
        end
        if (!isp_active) begin
            rst_seen_next = 1'b0;
        end else if (!link.oe_reset_n) begin
            rst_seen_next = 1'b1;
        end
        if (pulse_cnt_reg != 4'h0) begin
            pulse_cnt_next   = pulse_cnt_reg - 4'h1;
            reload_oe_n_next = 1'b0;
        end else if (link.tck_rise && tap_reg == TAP_UPD_IR && ir_sh_reg == `JIP_OP_RELOAD) begin
            pulse_cnt_next = 4'(`JIP_RELOAD_CYC);
        end
        float_next = isp_active || instruction_reg == `JIP_OP_FLOAT;
        clamp_next = instruction_reg == `JIP_OP_CLAMP;
        drive_next = instruction_reg == `JIP_OP_EXTEST || clamp_next;
        if (srst) begin
            lock_next        = 1'b0;
            rst_seen_next    = 1'b0;
            pulse_cnt_next   = 4'h0;
            reload_oe_n_next = 1'b1;
            float_next       = 1'b0;
            clamp_next       = 1'b0;
            drive_next       = 1'b0;
        end
    end

    always_ff @(posedge clk) begin
        lock_reg        <= lock_next;
        rst_seen_reg    <= rst_seen_next;
        pulse_cnt_reg   <= pulse_cnt_next;
        reload_oe_n_reg <= reload_oe_n_next;
        float_reg       <= float_next;
        clamp_reg       <= clamp_next;
        drive_reg       <= drive_next;
    end

    ////////////////////////////////////////////////////////////////////////
    // outputs
    assign tdo                = tdo_reg;
    assign tdo_oe_n           = tdo_oe_n_reg;
    assign target_reload_n    = 1'b0;
    assign target_reload_oe_n = reload_oe_n_reg;
    assign outputs_float      = float_reg;
    assign outputs_clamp      = clamp_reg;
    assign boundary_out       = bsr_reg;
    assign boundary_drive     = drive_reg;
    assign read_permit        = ~lock_reg;
    assign program_permit     = rst_seen_reg;
    assign isp_ready          = rst_seen_reg;
endmodule // jip_port
`default_nettype wire

/* verif/jip_host.sv */
// jtag host model: tck, tms, tdi and the oe/reset line
// assumes clk runs; tck only moves inside tick, 400 ns period
`timescale 1ns/1ns
`default_nettype none
module jip_host
(
    input  wire logic clk,
    input  wire logic tdo,
    output var  logic tck,
    output var  logic tms,
    output var  logic tdi,
    output var  logic oe_reset_n
);
    initial begin
        tck = 1'b0;
        tms = 1'b1;
        tdi = 1'b1;
        oe_reset_n = 1'b1;
    end
    // one tck period, tdo taken late in the high half
    task automatic tick(input logic m, input logic d, output logic q);
        @(posedge clk);
        #1 tms = m;
        tdi = d;
        repeat (3) @(posedge clk);
        #1 tck = 1'b1;
        repeat (3) @(posedge clk);
        #1 q = tdo;
        @(posedge clk);
        #1 tck = 1'b0;
    endtask
    task automatic reset_tap();
        logic q;
        repeat (5) tick(1'b1, 1'b1, q);
        tick(1'b0, 1'b1, q);
    endtask
    // idle to idle scan, bits lsb first
    task automatic scan(input logic ir, input int n, input logic [31:0] din, output logic [31:0] dout);
        logic q;
        dout = '0;
        tick(1'b1, 1'b1, q);
        if (ir) tick(1'b1, 1'b1, q);
        tick(1'b0, 1'b1, q);
        tick(1'b0, 1'b1, q);
        for (int i = 0; i < n; i++) begin
            tick(i == n - 1, din[i], q);
            dout[i] = q;
        end
        tick(1'b1, 1'b1, q);
        tick(1'b0, 1'b1, q);
    endtask
    task automatic pulse_oe();
        @(posedge clk);
        #1 oe_reset_n = 1'b0;
        repeat (6) @(posedge clk);
        #1 oe_reset_n = 1'b1;
    endtask
endmodule // jip_host
`default_nettype wire

/* verif/jip_port_chk.sv */
// assertions on the jtag instruction port top-level ports
// assumes a bind onto jip_port, one clock domain
`timescale 1ns/1ns
`default_nettype none
module jip_port_chk
(
    input wire logic clk,
    input wire logic srst,
    input wire logic oe_reset_n,
    input wire logic isp_active,
    input wire logic lock_program,
    input wire logic full_erase,
    input wire logic target_reload_n,
    input wire logic target_reload_oe_n,
    input wire logic outputs_float,
    input wire logic outputs_clamp,
    input wire logic boundary_drive,
    input wire logic read_permit,
    input wire logic program_permit
);
    default clocking @(posedge clk); endclocking
    default disable iff (srst);
    a_reload_width: assert property (
        $fell(target_reload_oe_n) |-> (!target_reload_oe_n)[*8] ##1 target_reload_oe_n) else $error("reload width");
    a_reload_once: assert property (
        $rose(target_reload_oe_n) |-> target_reload_oe_n[*8]) else $error("reload repeated");
    a_reload_low: assert property (
        !target_reload_oe_n |-> target_reload_n == 1'b0) else $error("reload not low");
    a_isp_float: assert property (
        isp_active |=> outputs_float) else $error("isp not floated");
    a_lock_set: assert property (
        lock_program |=> !read_permit) else $error("lock not set");
    a_erase_clear: assert property (
        full_erase && !lock_program |=> read_permit) else $error("erase kept lock");
    a_lock_hold: assert property (
        !read_permit && !full_erase |=> !read_permit) else $error("lock lost");
    a_isp_gate: assert property (
        !isp_active |=> !program_permit) else $error("permit outside isp");
    a_permit_cause: assert property (
        $rose(program_permit) |-> $past(isp_active) && (!$past(oe_reset_n, 2) || !$past(oe_reset_n, 3)))
        else $error("permit without reset");
    a_clamp_drive: assert property (
        outputs_clamp |-> boundary_drive) else $error("clamp not driven");
endmodule // jip_port_chk
bind jip_port jip_port_chk jip_port_chk_inst (.clk(clk), .srst(srst), .oe_reset_n(oe_reset_n),
    .isp_active(isp_active), .lock_program(lock_program), .full_erase(full_erase),
    .target_reload_n(target_reload_n), .target_reload_oe_n(target_reload_oe_n), .outputs_float(outputs_float),
    .outputs_clamp(outputs_clamp), .boundary_drive(boundary_drive), .read_permit(read_permit),
    .program_permit(program_permit));
`default_nettype wire

/* verif/jtag_isp_instruction_port_tb.sv */
// testbench of the jtag instruction port
// assumes jip_host as the far side and the bound checker
`timescale 1ns/1ns
`include "jip_cfg.svh"
`default_nettype none
module jtag_isp_instruction_port_tb;
    typedef struct packed {
        logic [7:0]  op;
        logic [2:0]  mode;
        logic [5:0]  len;
        logic [31:0] dr;
    } jip_row_t;
    jip_row_t rows [8] = '{'{8'hff, 3'h0, 6'd2, 32'h2}, '{8'h01, 3'h0, 6'd16, 32'hc3a5},
        '{8'h00, 3'h1, 6'd16, 32'hc3a5}, '{8'hfa, 3'h3, 6'd2, 32'h2}, '{8'hfc, 3'h4, 6'd2, 32'h2},
        '{8'hfe, 3'h0, 6'd32, `JIP_IDENT_WORD}, '{8'hfd, 3'h0, 6'd32, 32'h600df00d}, '{8'h5a, 3'h0, 6'd2, 32'h2}};
    logic        clk, srst, isp_active, lock_program, full_erase, tck, tms, tdi, oe_reset_n, prev_line;
    logic        tdo, tdo_oe_n, target_reload_n, target_reload_oe_n, outputs_float, outputs_clamp;
    logic        boundary_drive, read_permit, program_permit, isp_ready, user_word_valid;
    logic [15:0] boundary_out;
    logic [31:0] v;
    int          bad_count, n_tests, n_low, n_fall, cyc;
    wire logic   tdo_line = tdo_oe_n ? 1'b1 : tdo;
    wire logic   reload_line = target_reload_oe_n ? 1'b1 : target_reload_n;
    jip_port jip_port_inst (.clk(clk), .srst(srst), .tck(tck), .tms(tms), .tdi(tdi), .oe_reset_n(oe_reset_n),
        .isp_active(isp_active), .lock_program(lock_program), .full_erase(full_erase),
        .user_word_valid(user_word_valid), .user_word(32'h600df00d), .pins_in(16'hc3a5),
        .tdo(tdo), .tdo_oe_n(tdo_oe_n),
        .target_reload_n(target_reload_n), .target_reload_oe_n(target_reload_oe_n), .outputs_float(outputs_float),
        .outputs_clamp(outputs_clamp), .boundary_out(boundary_out), .boundary_drive(boundary_drive),
        .read_permit(read_permit), .program_permit(program_permit), .isp_ready(isp_ready));
    jip_host jip_host_inst (.clk(clk), .tdo(tdo_line), .tck(tck), .tms(tms), .tdi(tdi), .oe_reset_n(oe_reset_n));
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        n_tests++;
        if (seen !== exp) begin
            bad_count++;
            $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask
    task automatic finish_test();
        if (bad_count == 0 && n_tests > 0) $display("Finished cleanly");
        else $display("Finished with errors");
        $finish;
    endtask
    task automatic pulse(ref logic s);
        @(posedge clk);
        #1 s = 1'b1;
        @(posedge clk);
        #1 s = 1'b0;
    endtask
    task automatic ir(input logic [7:0] op, input logic [7:0] cap);
        jip_host_inst.scan(1'b1, 8, {24'h0, op}, v);
        check(v, {24'h0, cap});
    endtask
    initial begin
        clk = 1'b0;
        forever #25 clk = ~clk;
    end
    always @(posedge clk) begin
        cyc++;
        if (reload_line === 1'b0) n_low++;
        if (prev_line === 1'b1 && reload_line === 1'b0) n_fall++;
        prev_line <= reload_line;
        if (cyc == 20000) begin
            bad_count++;
            finish_test();
        end
    end
    ////////////////////////////////////////////////////////////////////////////////
    initial begin
        {srst, isp_active, lock_program, full_erase, user_word_valid} = 5'h11;
        repeat (12) @(posedge clk);
        #1 srst = 1'b0;
        repeat (4) @(posedge clk);
        jip_host_inst.reset_tap();
        jip_host_inst.scan(1'b0, 32, 32'h0, v);
        check(v, `JIP_IDENT_WORD);
        foreach (rows[i]) begin
            ir(rows[i].op, 8'h01);
            jip_host_inst.scan(1'b0, int'(rows[i].len), 32'h1234abcd, v);
            check(v, rows[i].dr);
            check(32'({outputs_float, outputs_clamp, boundary_drive}), 32'(rows[i].mode));
            if (rows[i].mode[0]) check(32'(boundary_out), 32'habcd);
        end
        {n_low, n_fall} = 0;
        ir(8'hee, 8'h01);
        repeat (40) @(posedge clk);
        check(32'(n_low * 50 >= 300 && n_low * 50 <= 500), 32'h1);
        check(32'(n_fall), 32'h1);
        @(posedge clk);
        #1 isp_active = 1'b1;
        repeat (8) @(posedge clk);
        check(32'({program_permit, outputs_float}), 32'h1);
        jip_host_inst.pulse_oe();
        repeat (8) @(posedge clk);
        check(32'({program_permit, isp_ready}), 32'h3);
        pulse(lock_program);
        ir(8'hfd, 8'h19);
        jip_host_inst.scan(1'b0, 32, 32'h0, v);
        check(v, 32'hffffffff);
        check(32'(read_permit), 32'h0);
        @(posedge clk);
        #1 isp_active = 1'b0;
        repeat (8) @(posedge clk);
        check(32'(program_permit), 32'h0);
        ir(8'hff, 8'h09);
        pulse(full_erase);
        ir(8'hfd, 8'h01);
        jip_host_inst.scan(1'b0, 32, 32'h0, v);
        check(v, 32'h600df00d);
        user_word_valid = 1'b0;
        ir(8'hfd, 8'h01);
        jip_host_inst.scan(1'b0, 32, 32'h0, v);
        check(v, `JIP_USER_BLANK);
        @(posedge clk);
        #1 srst = 1'b1;
        repeat (3) @(posedge clk);
        #1 srst = 1'b0;
        repeat (4) @(posedge clk);
        check(32'({tdo_oe_n, target_reload_oe_n, outputs_float}), 32'h6);
        jip_host_inst.reset_tap();
        jip_host_inst.scan(1'b0, 32, 32'h0, v);
        check(v, `JIP_IDENT_WORD);
        finish_test();
    end
endmodule // jtag_isp_instruction_port_tb
`default_nettype wire
